// file: hdl/tmr_pkg.sv
// Package: register map, field positions and encodings of the 8-bit timer
package tmr_pkg;
  localparam logic [3:0] TMR_ADR_CONTROL = 4'h0;
  localparam logic [3:0] TMR_ADR_COUNT = 4'h4;
  localparam logic [3:0] TMR_ADR_COMPARE = 4'h8;
  localparam logic [3:0] TMR_ADR_MASK = 4'hc;
  localparam logic [3:0] TMR_ADR_FLAGS = 4'h0 + 4'h0;
  localparam logic [7:0] TMR_ADR_FLAGS_B = 8'h10;
  localparam int TMR_BIT_FORCE = 7;
  localparam int TMR_BIT_WGM1 = 6;
  localparam int TMR_BIT_COM_HI = 5;
  localparam int TMR_BIT_COM_LO = 4;
  localparam int TMR_BIT_WGM0 = 3;
  localparam int TMR_BIT_CS_HI = 2;
  localparam int TMR_BIT_CMP = 1;
  localparam int TMR_BIT_OVF = 0;
  localparam logic [7:0] TMR_CONTROL_RST = 8'h00;
  localparam logic [7:0] TMR_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR_COMPARE_RST = 8'h00;
  localparam logic [7:0] TMR_MAX = 8'hff;
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMR_WGM_PCPWM = 2'h1;
  localparam logic [1:0] TMR_WGM_CTC = 2'h2;
  localparam logic [1:0] TMR_WGM_FAST = 2'h3;
  localparam logic [2:0] TMR_CS_OFF = 3'h0;
  localparam logic [2:0] TMR_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMR_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMR_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMR_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMR_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMR_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR_CS_EXT_RISE = 3'h7;
  localparam int TMR_PRE_W = 10;
endpackage

// file: hdl/tmr_prescaler.sv
// Prescaler taps and external-edge detect producing the timer tick
`timescale 1ns/1ps
module tmr_prescaler
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  input wire logic ext_pin,
  output logic tick
);
  logic [TMR_PRE_W-1:0] div_q;
  logic ext_q;
  logic ext_prev_q;
  logic tap;
  wire logic rise = ext_q & ~ext_prev_q;
  wire logic fall = ~ext_q & ext_prev_q;
  // A tap fires when its low bits are all ones, just before they wrap
  always_comb
  begin
    unique case (sel)
      TMR_CS_OFF: tap = 1'b0;
      TMR_CS_DIV1: tap = 1'b1;
      TMR_CS_DIV8: tap = (div_q[2:0] == 3'h7);
      TMR_CS_DIV64: tap = (div_q[5:0] == 6'h3f);
      TMR_CS_DIV256: tap = (div_q[7:0] == 8'hff);
      TMR_CS_DIV1024: tap = (div_q == 10'h3ff);
      TMR_CS_EXT_FALL: tap = fall;
      TMR_CS_EXT_RISE: tap = rise;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_q <= '0;
      // Start from the pin level so leaving reset makes no false edge
      ext_q <= ext_pin;
      ext_prev_q <= ext_pin;
    end
    else
    begin
      div_q <= div_q + 10'h001;
      ext_q <= ext_pin;
      ext_prev_q <= ext_q;
    end
  end
  assign tick = tap;
endmodule

// file: hdl/tmr_timer8.sv
// 8-bit timer/counter with one compare channel, Wishbone register slave
`timescale 1ns/1ps
// Operation
// - Force strobe in non-PWM mode applies the selected match action at once
// - Forced compare sets no flag, raises no request, never clears counter
// - Force strobe is not stored and always reads as zero
// - Mode field at control bits 6,3; TOP is compare value only in mode 2
// - Compare buffering and overflow flag point depend on the mode
// - Non-PWM output modes: off, toggle, clear, set on match
// - Fast PWM: off, toggle on match, clear/set on match with opposite at BOTTOM
// - Phase-correct: clear on up match, set on down match, or inverse
// - Fast PWM clear/set with compare at TOP: only the BOTTOM action happens
// - Phase-correct with compare at TOP: action happens at TOP instead
// - Nonzero output mode overrides the pin; software sets its direction
// - Clock source: stopped, divide 1/8/64/256/1024, external fall or rise
// - External edges count even when the pin is an output
// - Count register is read/write; a write blocks the next tick's match
// - Compare value is compared with the counter at all times
// - Compare request when enable, global enable and flag are all one
// - Overflow request when enable, global enable and flag are all one
// - Compare flag set on match; cleared by vector or written one
// - Overflow flag set on overflow; cleared by vector or written one
// - Phase-correct sets overflow flag at direction reversal at zero
// - Fast PWM counts up to MAX, then zero on the next tick
// - Phase-correct holds MAX for exactly one tick before counting down
module tmr_timer8
  import tmr_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic EXTERNAL_COUNT_PIN,
  input wire logic COMPARE_ACK,
  input wire logic OVERFLOW_ACK,
  output logic COMPARE_OUTPUT_PIN,
  output logic COMPARE_OUTPUT_OVERRIDE,
  output logic COMPARE_IRQ,
  output logic OVERFLOW_IRQ
);
  logic [6:0] control_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] compare_buf_q;
  logic [7:0] compare_q;
  logic [1:0] mask_q;
  logic cmp_flag_q;
  logic ovf_flag_q;
  logic down_q;
  logic down_d;
  logic block_q;
  logic out_q;
  logic out_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic tick;

  // Bus decode; only byte lane 0 carries the 8-bit registers
  wire logic req = WB_CYC_I & WB_STB_I & ~ack_q;
  wire logic wr = req & WB_WE_I & WB_SEL_I[0];
  wire logic wr_ctl = wr & (WB_ADR_I == {4'h0, TMR_ADR_CONTROL});
  wire logic wr_cnt = wr & (WB_ADR_I == {4'h0, TMR_ADR_COUNT});
  wire logic wr_cmp = wr & (WB_ADR_I == {4'h0, TMR_ADR_COMPARE});
  wire logic wr_msk = wr & (WB_ADR_I == {4'h0, TMR_ADR_MASK});
  wire logic wr_flg = wr & (WB_ADR_I == TMR_ADR_FLAGS_B);
  wire logic [7:0] wd = WB_DAT_I[7:0];

  wire logic [1:0] wgm = {control_q[TMR_BIT_WGM1], control_q[TMR_BIT_WGM0]};
  wire logic [1:0] com = control_q[TMR_BIT_COM_HI:TMR_BIT_COM_LO];
  wire logic [2:0] cs = control_q[TMR_BIT_CS_HI:0];
  wire logic pwm = wgm[0];
  wire logic is_fast = (wgm == TMR_WGM_FAST);
  wire logic is_pc = (wgm == TMR_WGM_PCPWM);
  wire logic is_ctc = (wgm == TMR_WGM_CTC);
  wire logic [7:0] top = is_ctc ? compare_q : TMR_MAX;
  // Continuous compare, masked on the tick after a count write
  wire logic match = tick & (count_q == compare_q) & ~block_q;
  wire logic force_cmp = wr_ctl & wd[TMR_BIT_FORCE] & ~pwm;
  wire logic at_top_tick = tick & (count_q == top);
  wire logic at_bottom_pc = tick & is_pc & down_q & (count_q == 8'h01);
  wire logic ovf_ev = is_pc ? at_bottom_pc : (tick & (count_q == TMR_MAX));
  wire logic cmp_top = (compare_q == TMR_MAX) & com[1];
  wire logic to_bottom = tick & is_fast & (count_q == TMR_MAX);
  // Buffered compare loads at TOP (phase-correct) or BOTTOM (fast PWM)
  wire logic load_cmp = ~pwm | (is_pc & at_top_tick) | to_bottom;

  // Counter sequencing per mode
  always_comb
  begin
    count_d = count_q;
    down_d = down_q;
    if (tick)
    begin
      if (is_pc)
      begin
        // Turn in the MAX tick itself so MAX lasts a single tick
        if (!down_q && count_q == TMR_MAX)
        begin
          down_d = 1'b1;
          count_d = count_q - 8'h01;
        end
        else if (down_q && count_q == 8'h01)
        begin
          down_d = 1'b0;
          count_d = TMR_BOTTOM;
        end
        else if (down_q)
          count_d = count_q - 8'h01;
        else
          count_d = count_q + 8'h01;
      end
      // A match blocked by a count write does not clear either
      else if (is_ctc && match)
        count_d = TMR_BOTTOM;
      else
        count_d = count_q + 8'h01;
    end
    if (!is_pc)
      down_d = 1'b0;
    if (wr_cnt)
      count_d = wd;
  end

  // Waveform generator; forced compare never touches counter or flags
  always_comb
  begin
    out_d = out_q;
    if (force_cmp)
    begin
      unique case (com)
        2'h0: out_d = out_q;
        2'h1: out_d = ~out_q;
        2'h2: out_d = 1'b0;
        2'h3: out_d = 1'b1;
      endcase
    end
    else if (!pwm && match)
    begin
      unique case (com)
        2'h0: out_d = out_q;
        2'h1: out_d = ~out_q;
        2'h2: out_d = 1'b0;
        2'h3: out_d = 1'b1;
      endcase
    end
    else if (is_fast && com[1])
    begin
      if (to_bottom)
        out_d = ~com[0];
      else if (match && !cmp_top)
        out_d = com[0];
    end
    else if (is_fast && com == 2'h1 && match)
      out_d = ~out_q;
    else if (is_pc && com[1])
    begin
      // At TOP the pin takes its down-count match level
      if (cmp_top && at_top_tick)
        out_d = ~com[0];
      else if (match && !cmp_top)
        out_d = down_q ? ~com[0] : com[0];
    end
  end

  // Read mux; the force strobe position always reads zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (WB_ADR_I)
      {4'h0, TMR_ADR_CONTROL}: rdata_d[6:0] = control_q;
      {4'h0, TMR_ADR_COUNT}: rdata_d[7:0] = count_q;
      {4'h0, TMR_ADR_COMPARE}: rdata_d[7:0] = compare_buf_q;
      {4'h0, TMR_ADR_MASK}: rdata_d[1:0] = mask_q;
      TMR_ADR_FLAGS_B: rdata_d[1:0] = {cmp_flag_q, ovf_flag_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      control_q <= TMR_CONTROL_RST[6:0];
      count_q <= TMR_COUNT_RST;
      compare_buf_q <= TMR_COMPARE_RST;
      compare_q <= TMR_COMPARE_RST;
      mask_q <= 2'h0;
      cmp_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      down_q <= 1'b0;
      block_q <= 1'b0;
      out_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      COMPARE_OUTPUT_PIN <= 1'b0;
      COMPARE_OUTPUT_OVERRIDE <= 1'b0;
      COMPARE_IRQ <= 1'b0;
      OVERFLOW_IRQ <= 1'b0;
    end
    else
    begin
      ack_q <= req;
      rdata_q <= rdata_d;
      if (wr_ctl)
        control_q <= wd[6:0];
      count_q <= count_d;
      // Block holds until the next tick consumes it
      if (wr_cnt)
        block_q <= 1'b1;
      else if (tick)
        block_q <= 1'b0;
      if (wr_cmp)
        compare_buf_q <= wd;
      if (load_cmp)
        compare_q <= wr_cmp & ~pwm ? wd : compare_buf_q;
      if (wr_msk)
        mask_q <= wd[1:0];
      // Hardware set wins over any clear in the same cycle
      if (match)
        cmp_flag_q <= 1'b1;
      else if (COMPARE_ACK || (wr_flg && wd[TMR_BIT_CMP]))
        cmp_flag_q <= 1'b0;
      if (ovf_ev)
        ovf_flag_q <= 1'b1;
      else if (OVERFLOW_ACK || (wr_flg && wd[TMR_BIT_OVF]))
        ovf_flag_q <= 1'b0;
      down_q <= down_d;
      out_q <= out_d;
      COMPARE_OUTPUT_PIN <= out_d;
      COMPARE_OUTPUT_OVERRIDE <= (control_q[5:4] != 2'h0);
      COMPARE_IRQ <= mask_q[TMR_BIT_CMP] & GLOBAL_IRQ_ENABLE & cmp_flag_q;
      OVERFLOW_IRQ <= mask_q[TMR_BIT_OVF] & GLOBAL_IRQ_ENABLE & ovf_flag_q;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

  // External edges reach the counter regardless of pin direction
  tmr_prescaler u_pre (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .sel(cs),
    .ext_pin(EXTERNAL_COUNT_PIN),
    .tick(tick)
  );
endmodule

// file: test/tmr_checker.sv
// Checker for bus handshake, read-back and request relations
`timescale 1ns/1ps
module tmr_checker (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic COMPARE_OUTPUT_OVERRIDE,
  input wire logic COMPARE_IRQ,
  input wire logic OVERFLOW_IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  wire req = WB_CYC_I && WB_STB_I;
  wire rd_ack = WB_ACK_O && !WB_WE_I;
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_taken: assert property (req && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
  a_ack_cause: assert property (!req |=> !WB_ACK_O)
    else $error("ack without a request");
  a_read_upper: assert property (rd_ack |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  a_unmapped_zero: assert property (rd_ack && WB_ADR_I > 8'h10
    |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_force_reads_zero: assert property (
    rd_ack && WB_ADR_I == 8'h00 |-> !WB_DAT_O[7])
    else $error("force strobe read back as one");
  a_override_mode: assert property (
    WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 8'h00
    |=> COMPARE_OUTPUT_OVERRIDE == ($past(WB_DAT_I[5:4]) != 2'h0))
    else $error("override does not follow output mode");
  a_gie_quiet: assert property (
    !GLOBAL_IRQ_ENABLE [*2] |-> !COMPARE_IRQ && !OVERFLOW_IRQ)
    else $error("request raised with global enable low");
endmodule
bind tmr_timer8 tmr_checker u_chk (.SYS_CLK, .RESETN, .WB_CYC_I,
  .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O,
  .WB_ACK_O, .GLOBAL_IRQ_ENABLE, .COMPARE_OUTPUT_OVERRIDE, .COMPARE_IRQ,
  .OVERFLOW_IRQ);

// file: test/timer8_compare_pwm_regs_bench.sv
// Self-checking bench for the 8-bit timer through its Wishbone registers
`timescale 1ns/1ps
module timer8_compare_pwm_regs_bench;
  import tmr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic ack, pin, ovr, cirq, oirq;
  logic gie = 1'b0;
  logic ext = 1'b0;
  logic cack = 1'b0;
  logic oack = 1'b0;
  logic [31:0] rd;
  int fail_count = 0;
  int n_checks = 0;
  int highs;
  tmr_timer8 dut (.SYS_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .GLOBAL_IRQ_ENABLE(gie), .EXTERNAL_COUNT_PIN(ext),
    .COMPARE_ACK(cack), .OVERFLOW_ACK(oack), .COMPARE_OUTPUT_PIN(pin),
    .COMPARE_OUTPUT_OVERRIDE(ovr), .COMPARE_IRQ(cirq), .OVERFLOW_IRQ(oirq));
  initial
    forever #12.5 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled; the bound cuts a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dw <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  // Bit 2 overflow ack, bit 1 compare ack, bit 0 count pin
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {oack, cack, ext} <= m;
    @(posedge clk);
    {oack, cack, ext} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rchk(8'(i * 4), 8'h00);
    // Set, clear, toggle, toggle from a high pin
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 8'h00, {2'b00, 2'(3 - (i > 2 ? 2 : i)), 4'h0});
      wb(1'b1, 8'h00, {2'b10, 2'(3 - (i > 2 ? 2 : i)), 4'h0});
      repeat (3) @(posedge clk);
      chk(pin, 32'(~i & 1));
      chk(ovr, 1);
    end
    rchk(8'h00, 8'h10);
    rchk(8'h10, 8'h00);
    wb(1'b1, 8'h04, 8'h5a);
    rchk(8'h04, 8'h5a);
    wb(1'b1, 8'h08, 8'h10);
    wb(1'b1, 8'h04, 8'h0c);
    wb(1'b1, 8'h0c, 8'h03);
    rchk(8'h0c, 8'h03);
    gie <= 1'b1;
    wb(1'b1, 8'h00, 8'h01);
    repeat (8) @(posedge clk);
    wb(1'b1, 8'h00, 8'h00);
    rchk(8'h10, 8'h02);
    chk(cirq, 1);
    pulse(3'b010);
    rchk(8'h10, 8'h00);
    chk(cirq, 0);
    wb(1'b1, 8'h04, 8'hfd);
    wb(1'b1, 8'h00, 8'h01);
    repeat (8) @(posedge clk);
    wb(1'b1, 8'h00, 8'h00);
    rchk(8'h10, 8'h01);
    chk(oirq, 1);
    gie <= 1'b0;
    wb(1'b1, 8'h10, 8'h00);
    rchk(8'h10, 8'h01);
    chk(oirq, 0);
    wb(1'b1, 8'h10, 8'h01);
    rchk(8'h10, 8'h00);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'h07);
    repeat (3)
      pulse(3'b001);
    wb(1'b1, 8'h00, 8'h00);
    rchk(8'h04, 8'h03);
    // Phase-correct on pin edges: one tick at MAX, overflow at zero
    wb(1'b1, 8'h04, 8'hfd);
    wb(1'b1, 8'h00, 8'h0f);
    repeat (4)
      pulse(3'b001);
    rchk(8'h04, 8'hfd);
    wb(1'b1, 8'h04, 8'h01);
    pulse(3'b001);
    rchk(8'h10, 8'h01);
    wb(1'b1, 8'h00, 8'h00);
    pulse(3'b100);
    rchk(8'h10, 8'h00);
    // Clear-on-match must never pass the compare value
    wb(1'b1, 8'h08, 8'h05);
    wb(1'b1, 8'h00, 8'h41);
    for (int i = 0; i < 5; i++)
    begin
      repeat (60) @(posedge clk);
      wb(1'b0, 8'h04, 8'h00);
      chk(32'(rd <= 32'h5), 1);
    end
    wb(1'b1, 8'h00, 8'h00);
    rchk(8'h10, 8'h02);
    // Duty over 1020 cycles: fast half, phase-correct a quarter
    for (int m = 0; m < 2; m++)
    begin
      wb(1'b1, 8'h00, 8'h00);
      wb(1'b1, 8'h08, m ? 8'h40 : 8'h80);
      wb(1'b1, 8'h00, m ? 8'h29 : 8'h69);
      repeat (600) @(posedge clk);
      highs = 0;
      repeat (1020)
      begin
        @(posedge clk);
        highs += int'(pin);
      end
      chk(32'(highs > (m ? 246 : 500) && highs < (m ? 266 : 520)), 1);
    end
    // Compare at MAX: phase-correct sets at TOP, fast PWM at BOTTOM
    wb(1'b1, 8'h08, 8'hff);
    repeat (1100) @(posedge clk);
    chk(pin, 1);
    wb(1'b1, 8'h00, 8'h69);
    repeat (600) @(posedge clk);
    chk(pin, 1);
    finish_test();
  end
endmodule
